// ### hdl/rplf_consts.svh
// Constants of the packet length framer: buffer size, widths, flag level, delays.
// Assumes inclusion by the framer package and the framer module only.
`ifndef RPLF_CONSTS_SVH
`define RPLF_CONSTS_SVH
`define RPLF_FIFO_DEPTH 64
`define RPLF_PTR_W 6
`define RPLF_RX_FLAG_LEVEL 7'h3f
`define RPLF_CLK_PERIOD_NS 25
`define RPLF_SETTLE_NS 1000
`define RPLF_SETTLE_CYC \
   ((`RPLF_SETTLE_NS + `RPLF_CLK_PERIOD_NS - 1) / `RPLF_CLK_PERIOD_NS)
`define RPLF_CHAN_W 7
`endif

// ### hdl/rplf_framer.sv
// Packet length framer: start and stop of transmit and receive packets,
// payload buffer pointers, packet and FIFO flags.
// Assumes a host sets the go bits and streams bytes; the modem supplies
// byte strobes for sent and received bytes and a sync detect pulse.
`timescale 1ns/1ps
`include "rplf_consts.svh"

// Behaviour
// - Length mode set: first payload byte is the packet length.
// - Length mode clear: first byte is data; end by empty or go bit.
// - Length byte not counted, 0 to 255; transmit stops after that many.
// - Stop-on-empty with length mode clear: compare pointers, end transmit when buffer empties.
// - Both mode bits clear: transmit until host clears transmit-go.
// - Transmit-go builds and sends a packet from the buffer.
// - Channel is captured when transmit-go rises.
// - In transmit, the FIFO flag shows buffer empty.
// - Flags active high by default; a bit makes both active low.
// - Receive-go turns receiver on; after settling, sync search starts.
// - Length mode receive ends automatically and returns to idle.
// - Receive of 63 bytes or more raises FIFO flag; host must drain.
// - Length mode off: packet flag on sync, then bytes fill buffer.
// - Packet flag holds until first byte read, then off until next period.
// - Length mode off: receive lasts until receive-go clears.
// - Sync clears both pointers on receive; read pointer after tx sync.
module rplf_framer (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Configuration and control
   input wire logic length_byte_mode,
   input wire logic stop_on_empty,
   input wire logic flag_active_low,
   input wire logic [6:0] channel_number,
   input wire logic tx_go,
   input wire logic rx_go,
   input wire logic wr_ptr_clear,
   // Host side of the buffer
   input wire logic host_wr,
   input wire logic [7:0] host_wr_data,
   input wire logic host_rd,
   output logic [7:0] host_rd_data,
   // Modem side
   input wire logic modem_tx_taken,
   output logic [7:0] modem_tx_data,
   output logic modem_tx_sync_sent,
   input wire logic modem_sync_found,
   input wire logic modem_rx_valid,
   input wire logic [7:0] modem_rx_data,
   // Status
   output logic tx_on,
   output logic rx_on,
   output logic [6:0] active_channel,
   output logic [5:0] fill_level,
   output logic packet_flag,
   output logic fifo_flag
);
   logic [7:0] mem [0:`RPLF_FIFO_DEPTH-1];
   rplf_pkg::rplf_state_t state_reg, state_next;
   logic [5:0] wp_reg, rp_reg;
   logic [7:0] len_reg, cnt_reg;
   logic lmode_reg, soe_reg, pkt_reg, ff_reg, first_rd_reg;
   logic [6:0] chan_reg;
   logic [15:0] settle_reg;
   logic tx_go_d, rx_go_d;
   logic [7:0] rd_data_reg;

   // Decode of events
   wire tx_start = tx_go & ~tx_go_d;
   wire rx_start = rx_go & ~rx_go_d & ~tx_go;
   wire empty = (wp_reg == rp_reg);
   wire settled = (settle_reg == 16'h0000);
   wire in_tx = (state_reg == rplf_pkg::rplf_tx_len) |
                (state_reg == rplf_pkg::rplf_tx_data);
   wire in_rx = (state_reg == rplf_pkg::rplf_rx_data);
   wire tx_pop = in_tx & modem_tx_taken & ~empty;
   wire rx_push = in_rx & modem_rx_valid;
   wire sync_hit = (state_reg == rplf_pkg::rplf_rx_search) & modem_sync_found;
   wire host_pop = host_rd & ~empty;
   wire [5:0] level = wp_reg - rp_reg;
   wire len_done = lmode_reg & (cnt_reg == len_reg);

   // Next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         rplf_pkg::rplf_idle: begin
            if (tx_start)
               state_next = rplf_pkg::rplf_tx_settle;
            else if (rx_start)
               state_next = rplf_pkg::rplf_rx_settle;
         end
         rplf_pkg::rplf_tx_settle:
            if (settled)
               state_next = rplf_pkg::rplf_tx_len;
         rplf_pkg::rplf_tx_len:
            // length byte taken; else plain data
            if (tx_pop)
               state_next = rplf_pkg::rplf_tx_data;
         rplf_pkg::rplf_tx_data: begin
            if (len_done)
               state_next = rplf_pkg::rplf_idle;
            else if (~lmode_reg & soe_reg & empty)
               state_next = rplf_pkg::rplf_idle;
         end
         rplf_pkg::rplf_rx_settle:
            if (settled)
               state_next = rplf_pkg::rplf_rx_search;
         rplf_pkg::rplf_rx_search:
            if (modem_sync_found)
               state_next = rplf_pkg::rplf_rx_data;
         rplf_pkg::rplf_rx_data:
            if (len_done & (cnt_reg != 8'h00 | len_reg == 8'h00) &
                first_rd_reg)
               state_next = rplf_pkg::rplf_idle;
         default: state_next = rplf_pkg::rplf_idle;
      endcase
      if (in_tx | state_reg == rplf_pkg::rplf_tx_settle)
         if (~tx_go)
            state_next = rplf_pkg::rplf_idle;
      if (state_reg == rplf_pkg::rplf_rx_settle |
          state_reg == rplf_pkg::rplf_rx_search | in_rx)
         if (~rx_go)
            state_next = rplf_pkg::rplf_idle;
   end

   // Control registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= rplf_pkg::rplf_idle;
         tx_go_d <= 1'b0;
         rx_go_d <= 1'b0;
         lmode_reg <= 1'b0;
         soe_reg <= 1'b0;
         chan_reg <= 7'h00;
         settle_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         tx_go_d <= tx_go;
         rx_go_d <= rx_go;
         if (state_reg == rplf_pkg::rplf_idle & (tx_start | rx_start)) begin
            lmode_reg <= length_byte_mode;
            soe_reg <= stop_on_empty;
            chan_reg <= channel_number;
            settle_reg <= 16'(`RPLF_SETTLE_CYC);
         end else if (!settled) begin
            settle_reg <= settle_reg - 16'h0001;
         end
      end
   end

   // Length and byte count; the length byte itself is never counted
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         len_reg <= 8'h00;
         cnt_reg <= 8'h00;
         first_rd_reg <= 1'b0;
      end else begin
         if (state_reg == rplf_pkg::rplf_tx_len & tx_pop) begin
            len_reg <= mem[rp_reg];
            cnt_reg <= 8'h00;
         end else if (state_reg == rplf_pkg::rplf_tx_data & tx_pop) begin
            cnt_reg <= cnt_reg + 8'h01;
         end
         if (sync_hit) begin
            cnt_reg <= 8'h00;
            first_rd_reg <= 1'b0;
         end else if (rx_push) begin
            if (!first_rd_reg) begin
               len_reg <= modem_rx_data;
               first_rd_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 8'h01;
            end
         end
      end
   end

   // Buffer pointers, shared by both directions
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wp_reg <= 6'h00;
         rp_reg <= 6'h00;
      end else begin
         if (sync_hit) begin
            wp_reg <= 6'h00;
            rp_reg <= 6'h00;
         end else begin
            if (wr_ptr_clear)
               wp_reg <= 6'h00;
            else if (host_wr & ~in_rx | rx_push)
               wp_reg <= wp_reg + 6'h01;
            if (modem_tx_sync_sent)
               rp_reg <= 6'h00;
            else if (tx_pop | host_pop & ~in_tx)
               rp_reg <= rp_reg + 6'h01;
         end
      end
   end

   // Buffer storage; no reset needed on data
   always_ff @(posedge ref_clk) begin
      if (rx_push)
         mem[wp_reg] <= modem_rx_data;
      else if (host_wr & ~in_rx)
         mem[wp_reg] <= host_wr_data; // Host writes ignored while receiving
   end

   // Flags and read data
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pkt_reg <= 1'b0;
         ff_reg <= 1'b0;
         rd_data_reg <= 8'h00;
      end else begin
         // set on sync; clear on first read
         if (sync_hit)
            pkt_reg <= 1'b1;
         else if (host_pop | tx_start | rx_start)
            pkt_reg <= 1'b0;
         // empty in transmit; rx level at 63
         if (in_tx)
            ff_reg <= empty;
         else if (in_rx)
            ff_reg <= ({1'b0, level} >= `RPLF_RX_FLAG_LEVEL);
         else
            ff_reg <= 1'b0;
         if (host_pop)
            rd_data_reg <= mem[rp_reg];
      end
   end

   // Outputs; polarity select
   assign packet_flag = pkt_reg ^ flag_active_low;
   assign fifo_flag = ff_reg ^ flag_active_low;
   assign host_rd_data = rd_data_reg;
   assign modem_tx_data = mem[rp_reg];
   assign modem_tx_sync_sent = (state_reg == rplf_pkg::rplf_tx_settle) &
                               settled;
   assign tx_on = in_tx;
   assign rx_on = (state_reg == rplf_pkg::rplf_rx_search) | in_rx;
   assign active_channel = chan_reg;
   assign fill_level = level;
endmodule

// ### hdl/rplf_pkg.sv
// Types of the packet length framer.
// Assumes rplf_consts.svh is on the include path.
`include "rplf_consts.svh"
package rplf_pkg;
   typedef enum logic [2:0] {
      rplf_idle, rplf_tx_settle, rplf_tx_len, rplf_tx_data,
      rplf_rx_settle, rplf_rx_search, rplf_rx_data
   } rplf_state_t;
endpackage

// ### testbench/rplf_framer_chk.sv
// Checker: timing properties on the framer ports.
// Assumes one clock domain; bound to every framer instance below.
`timescale 1ns/1ps
module rplf_framer_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Inputs watched
   input wire logic flag_active_low,
   input wire logic tx_go,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic modem_sync_found,
   input wire logic modem_rx_valid,
   // Outputs watched
   input wire logic modem_tx_sync_sent,
   input wire logic tx_on,
   input wire logic rx_on,
   input wire logic [6:0] active_channel,
   input wire logic [5:0] fill_level,
   input wire logic packet_flag,
   input wire logic fifo_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Quiet sync pulse; the bench only sends it while searching
   wire logic sync_in = modem_sync_found && !tx_on && !modem_rx_valid
      && !host_wr;
   // Properties
   tx_rx_excl_a:
   assert property (!(tx_on && rx_on)) else $error("tx and rx both on");
   settle_time_a:
   assert property ($rose(tx_go) && !tx_on && !rx_on |-> ##[40:42]
      modem_tx_sync_sent) else $error("sync not sent after settle");
   chan_hold_a:
   assert property (tx_on && $past(tx_on) |-> $stable(active_channel))
      else $error("channel moved in transmit");
   tx_stop_a:
   assert property (tx_on && !tx_go |-> ##[1:2] !tx_on)
      else $error("transmit kept after go cleared");
   sync_ptr_a:
   assert property (sync_in |=> fill_level == 6'h00)
      else $error("pointers kept after sync");
   pkt_on_a:
   assert property (sync_in |=> packet_flag != flag_active_low)
      else $error("packet flag not set on sync");
   pkt_clear_a:
   assert property (host_rd && rx_on && fill_level != 6'h00 &&
      !modem_sync_found |=> packet_flag == flag_active_low)
      else $error("packet flag kept after read");
   tx_empty_a:
   assert property (tx_on && $past(tx_on) && $past(fill_level) == 6'h00
      |-> fifo_flag != flag_active_low) else $error("empty not flagged");
   rx_level_a:
   assert property (rx_on && $past(rx_on) && $past(fill_level) == 6'h3f
      |-> fifo_flag != flag_active_low) else $error("level not flagged");
endmodule
bind rplf_framer rplf_framer_chk chk (.*);

// ### testbench/rplf_framer_tb.sv
// Bench: transmit mode table, then reset, receive and flag cases.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
module rplf_framer_tb;
   typedef struct {
      logic lbm, soe;
      logic [7:0] first, nload, takes;
   } rplf_row_t;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic length_byte_mode, stop_on_empty, flag_active_low;
   logic tx_go, rx_go, wr_ptr_clear, host_wr, host_rd;
   logic modem_tx_taken, modem_sync_found, modem_rx_valid;
   logic modem_tx_sync_sent, tx_on, rx_on, packet_flag, fifo_flag;
   logic [6:0] channel_number, active_channel;
   logic [7:0] host_wr_data, host_rd_data, modem_tx_data, modem_rx_data;
   logic [5:0] fill_level;
   int failures = 0, tests_run = 0, cycles = 0;
   logic [7:0] taken, exp_byte;
   // Length byte 3 and 0, stop on empty, run until go clears
   rplf_row_t rows[4] = '{'{1, 0, 3, 4, 4}, '{1, 1, 0, 3, 1},
      '{0, 1, 8'h10, 3, 3}, '{0, 0, 1, 2, 6}};
   rplf_framer DUT (.*);
   rplf_host_model host (.*);
   // Clock and hang guard; a hang counts as a mismatch
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Modem strobes: sync, then n received bytes counting up
   task automatic rx_feed(logic sync, int n, logic [7:0] first);
      modem_sync_found = sync;
      @(negedge ref_clk) modem_sync_found = 1'b0;
      for (int k = 0; k < n; k++) begin
         modem_rx_valid = 1'b1;
         modem_rx_data = first + 8'(k);
         @(negedge ref_clk);
      end
      modem_rx_valid = 1'b0;
      modem_rx_data = ~modem_rx_data; // Idle line shows no old byte
   endtask
   // Main sequence
   initial begin
      {length_byte_mode, stop_on_empty, flag_active_low} = 3'h0;
      {modem_tx_taken, modem_sync_found, modem_rx_valid} = 3'h0;
      modem_rx_data = 8'h00;
      repeat (10) @(negedge ref_clk);
      rstn = 1'b1;
      foreach (rows[r]) begin
         {length_byte_mode, stop_on_empty} = {rows[r].lbm, rows[r].soe};
         host.load(rows[r].nload, rows[r].first);
         host.go(1'b1, 1'b0, 7'(r + 5));
         host.go(1'b1, 1'b0, 7'h7f);
         for (int n = 0; n < 60 && modem_tx_sync_sent !== 1'b1; n++)
            @(negedge ref_clk);
         check("sync sent", 8'h01, 8'(modem_tx_sync_sent));
         check("channel", 8'(r + 5), 8'(active_channel));
         @(negedge ref_clk);
         taken = 8'h00;
         for (int k = 0; k < 6; k++) begin
            if (tx_on === 1'b1) begin
               if (k < rows[r].nload) begin
                  exp_byte = rows[r].first + 8'(k);
                  check("tx byte", exp_byte, modem_tx_data);
               end
               modem_tx_taken = 1'b1;
               @(negedge ref_clk) modem_tx_taken = 1'b0;
               @(negedge ref_clk);
               taken++;
            end
         end
         check("bytes sent", rows[r].takes, taken);
         if (!rows[r].lbm && !rows[r].soe)
            check("empty", 8'h01, 8'(fifo_flag));
         host.go(1'b0, 1'b0, 7'h00);
         @(negedge ref_clk) check("tx end", 8'h00, 8'(tx_on));
      end
      // Reset in mid-run with active-low flags
      flag_active_low = 1'b1;
      rstn = 1'b0;
      @(negedge ref_clk) check("reset flag", 8'h01, 8'(packet_flag));
      rstn = 1'b1;
      // Streaming receive: flags, level, first read, go bit ends it
      {length_byte_mode, stop_on_empty} = 2'b01;
      host.go(1'b0, 1'b1, 7'h21);
      repeat (45) @(negedge ref_clk);
      check("rx search", 8'h01, 8'(rx_on));
      check("rx chan", 8'h21, 8'(active_channel));
      rx_feed(1'b1, 0, 8'h00);
      check("pkt on", 8'h00, 8'(packet_flag));
      rx_feed(1'b0, 63, 8'h40);
      @(negedge ref_clk) check("level", 8'h3f, 8'(fill_level));
      check("fifo on", 8'h00, 8'(fifo_flag));
      host.pop();
      check("rd data", 8'h40, host_rd_data);
      check("pkt off", 8'h01, 8'(packet_flag));
      check("rx kept", 8'h01, 8'(rx_on));
      host.go(1'b0, 1'b0, 7'h00);
      @(negedge ref_clk) check("rx end", 8'h00, 8'(rx_on));
      // Length mode receive stops by itself
      {flag_active_low, length_byte_mode} = 2'b01;
      host.go(1'b0, 1'b1, 7'h02);
      repeat (45) @(negedge ref_clk);
      rx_feed(1'b1, 3, 8'h02);
      @(negedge ref_clk) check("rx auto end", 8'h00, 8'(rx_on));
      host.go(1'b0, 1'b0, 7'h00);
      tally_and_finish();
   end
endmodule

// ### testbench/rplf_host_model.sv
// Host model: clears and loads the buffer, pops bytes, drives go bits.
// Assumes the bench calls its tasks at a falling edge of the clock.
`timescale 1ns/1ps
module rplf_host_model (
   // Clock
   input wire logic ref_clk,
   // Host controls
   output logic tx_go,
   output logic rx_go,
   output logic [6:0] channel_number,
   output logic wr_ptr_clear,
   output logic host_wr,
   output logic [7:0] host_wr_data,
   output logic host_rd
);
   // Quiet levels at time zero
   initial begin
      {tx_go, rx_go, wr_ptr_clear, host_wr, host_rd} = 5'h00;
      channel_number = 7'h00;
      host_wr_data = 8'h00;
   end
   // clear, then load n bytes counting up; at most 63 fit
   task automatic load(input int n, input logic [7:0] first);
      @(negedge ref_clk) wr_ptr_clear = 1'b1;
      @(negedge ref_clk) wr_ptr_clear = 1'b0;
      for (int i = 0; i < n; i++) begin
         host_wr = 1'b1;
         host_wr_data = first + 8'(i);
         @(negedge ref_clk);
      end
      host_wr = 1'b0;
      host_wr_data = ~host_wr_data; // Released bus keeps no old byte
   endtask
   // channel with go, caller's timeout clears go
   task automatic go(input logic t, input logic r, input logic [6:0] ch);
      @(negedge ref_clk);
      channel_number = ch;
      tx_go = t;
      rx_go = r;
   endtask
   // Pop one byte
   task automatic pop();
      @(negedge ref_clk) host_rd = 1'b1;
      @(negedge ref_clk) host_rd = 1'b0;
   endtask
endmodule
